// >>> rtl/tei_cfg.svh
// Offsets, field positions, reset values and timing counts of the pin conditioning block
`ifndef TEI_CFG_SVH
`define TEI_CFG_SVH

// ==========================================================
// Register byte offsets
`define TEI_OFF_TIMER_CTL   12'h000
`define TEI_OFF_FLAGS       12'h004
`define TEI_OFF_COUNT_A     12'h008
`define TEI_OFF_COUNT_B     12'h00C

// ==========================================================
// Field positions
`define TEI_CH_STRIDE       4
`define TEI_PM_LSB          8
`define TEI_FLG_IRQ_LSB     0
`define TEI_FLG_OVF_LSB     2
`define TEI_FLG_IPIN_LSB    4
`define TEI_FLG_CPIN_LSB    6

// ==========================================================
// Reset values
`define TEI_CTRL_RST        8'h00
`define TEI_COUNT_RST       16'h0000
`define TEI_SYNC_RST        4'hF

// ==========================================================
// Timing
`define TEI_CLK_NS          10
`define TEI_TICK_NS         120
`define TEI_TICK_CYC        (`TEI_TICK_NS / `TEI_CLK_NS)

`endif

// >>> rtl/tei_pkg.sv
// Types shared by the pin conditioning block and its bench
package tei_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tei_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tei_apb_rsp_t;

  typedef struct packed {
    logic cnt_mode;
    logic edge_sel;
    logic gate;
    logic run;
  } tei_chan_cfg_t;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_IDLE,
    PM_DOWN
  } tei_pm_t;

endpackage

// >>> rtl/tei_top.sv
// Timer pin, count pin and external interrupt pin conditioning with APB registers
//
// What this block does
// - Each of the two timers holds a 16-bit count that wraps.
// - With pin run control on, interrupt pin a gates timer a.
// - Edge select a set: falling edge on pin a sets flag a.
// - Edge select a clear: low level on pin a sets flag a.
// - With pin run control on, interrupt pin b gates timer b.
// - Edge select b set: falling edge on pin b sets flag b.
// - Edge select b clear: low level on pin b sets flag b.
// - Counter mode a: each falling edge on count pin a adds one.
// - Counter mode b: each falling edge on count pin b adds one.
// - Idle halts the processor; timers and interrupt flags keep running.
// - Power down freezes the timers; an external interrupt still wakes.
`timescale 1ns/1ps
`include "tei_cfg.svh"

module tei_top (
  input  wire logic                  MCLK_I,
  input  wire logic                  RESETN_I,
  input  wire tei_pkg::tei_apb_req_t APB_I,
  output      tei_pkg::tei_apb_rsp_t APB_O,
  input  wire logic                  EXT_IRQ_PIN_A_I,
  input  wire logic                  EXT_IRQ_PIN_B_I,
  input  wire logic                  COUNT_PIN_A_I,
  input  wire logic                  COUNT_PIN_B_I,
  input  wire logic                  IRQ_ACK_A_I,
  input  wire logic                  IRQ_ACK_B_I,
  output      logic                  IRQ_REQUEST_FLAG_A_O,
  output      logic                  IRQ_REQUEST_FLAG_B_O,
  output      logic                  CPU_HALT_O,
  output      logic                  PERIPH_CLK_EN_O
);
  import tei_pkg::*;

  // ==========================================================
  // Functions
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `TEI_OFF_TIMER_CTL) || (a == `TEI_OFF_FLAGS) ||
              (a == `TEI_OFF_COUNT_A) || (a == `TEI_OFF_COUNT_B);
  endfunction

  function automatic logic [1:0] pm_bits(input tei_pm_t pm);
    unique case (pm)
      PM_RUN:  pm_bits = 2'h0;
      PM_IDLE: pm_bits = 2'h1;
      PM_DOWN: pm_bits = 2'h2;
    endcase
  endfunction

  // ==========================================================
  // Declarations
  logic [3:0]    pins;
  logic [3:0]    s1_q;
  logic [3:0]    s2_q;
  logic [3:0]    s3_q;
  logic [7:0]    ctrl_q;
  tei_pm_t       pm_q;
  logic [3:0]    tick_q;
  logic          tick;
  logic          periph_on;
  logic          wake;
  logic [31:0]   rd_d;
  logic [31:0]   rd_q;
  logic          err_q;
  logic          wr_en;
  logic          wr_ctrl;
  logic          wr_flags;
  logic          irq_q [2];
  logic          ovf_q [2];
  logic [15:0]   cnt_q [2];
  logic          inc [2];
  logic          wr_cnt [2];
  logic          run_en [2];
  logic          ack [2];
  tei_chan_cfg_t cfg [2];

  assign pins = {COUNT_PIN_B_I, COUNT_PIN_A_I, EXT_IRQ_PIN_B_I, EXT_IRQ_PIN_A_I};
  assign ack[0] = IRQ_ACK_A_I;
  assign ack[1] = IRQ_ACK_B_I;

  // ==========================================================
  // Pin synchronisers
  // two-flop synchroniser
  // Reset high so an idle-high pin gives no false edge at release
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s1_q <= `TEI_SYNC_RST;
      s2_q <= `TEI_SYNC_RST;
      s3_q <= `TEI_SYNC_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // APB slave
  assign wr_en    = APB_I.psel & APB_I.penable & APB_I.pwrite;
  assign wr_ctrl  = wr_en & (APB_I.paddr == `TEI_OFF_TIMER_CTL);
  assign wr_flags = wr_en & (APB_I.paddr == `TEI_OFF_FLAGS);
  assign wr_cnt[0] = wr_en & (APB_I.paddr == `TEI_OFF_COUNT_A);
  assign wr_cnt[1] = wr_en & (APB_I.paddr == `TEI_OFF_COUNT_B);

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (APB_I.paddr)
      `TEI_OFF_TIMER_CTL: rd_d = {22'h0, pm_bits(pm_q), ctrl_q};
      `TEI_OFF_FLAGS:     rd_d = {24'h0, ~s2_q[3:2], ~s2_q[1:0], ovf_q[1], ovf_q[0],
                                  irq_q[1], irq_q[0]};
      `TEI_OFF_COUNT_A:   rd_d = {16'h0, cnt_q[0]};
      `TEI_OFF_COUNT_B:   rd_d = {16'h0, cnt_q[1]};
      default:            rd_d = 32'h0000_0000;
    endcase
  end

  // Read data and error are latched in setup so the access phase needs no wait
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rd_q  <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (APB_I.psel && !APB_I.penable) begin
      rd_q  <= APB_I.pwrite ? 32'h0000_0000 : rd_d;
      err_q <= ~addr_ok(APB_I.paddr);
    end
  end

  assign APB_O.prdata  = rd_q;
  assign APB_O.pready  = 1'b1;
  assign APB_O.pslverr = err_q & APB_I.psel & APB_I.penable;

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl_q <= `TEI_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= APB_I.pwdata[7:0];
    end
  end

  // ==========================================================
  // Power modes
  assign wake      = (pm_q != PM_RUN) & (irq_q[0] | irq_q[1]);
  assign periph_on = (pm_q != PM_DOWN);

  // interrupt wakes; wake beats a software write
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pm_q <= PM_RUN;
    end else if (wake) begin
      pm_q <= PM_RUN;
    end else if (wr_ctrl) begin
      unique case (APB_I.pwdata[`TEI_PM_LSB +: 2])
        2'h0:    pm_q <= PM_RUN;
        2'h1:    pm_q <= PM_IDLE;
        2'h2:    pm_q <= PM_DOWN;
        default: pm_q <= pm_q;
      endcase
    end
  end

  assign CPU_HALT_O      = (pm_q != PM_RUN);
  assign PERIPH_CLK_EN_O = periph_on;

  // ==========================================================
  // Timer tick divider
  // divider frozen with the peripheral clock
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tick_q <= 4'h0;
    end else if (periph_on) begin
      tick_q <= tick ? 4'h0 : tick_q + 4'h1;
    end
  end
  assign tick = periph_on && (tick_q == 4'(`TEI_TICK_CYC - 1));

  // ==========================================================
  // Channels
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    assign cfg[ch] = tei_chan_cfg_t'(ctrl_q[ch*`TEI_CH_STRIDE +: `TEI_CH_STRIDE]);

    // interrupt pin gates the run bit
    assign run_en[ch] = cfg[ch].run & (~cfg[ch].gate | s2_q[ch]) & periph_on;

    // count pin of this channel in counter mode, the shared tick otherwise
    assign inc[ch] = run_en[ch] &
                     (cfg[ch].cnt_mode ? fell(s3_q[ch+2], s2_q[ch+2]) : tick);

    // 16-bit count, software load wins over a step
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
        cnt_q[ch] <= `TEI_COUNT_RST;
      end else if (wr_cnt[ch]) begin
        cnt_q[ch] <= APB_I.pwdata[15:0];
      end else if (inc[ch]) begin
        cnt_q[ch] <= cnt_q[ch] + 16'h0001;
      end
    end

    // Wrap marker, set beats clear
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
        ovf_q[ch] <= 1'b0;
      end else if (inc[ch] && !wr_cnt[ch] && cnt_q[ch] == 16'hFFFF) begin
        ovf_q[ch] <= 1'b1;
      end else if (wr_flags && APB_I.pwdata[`TEI_FLG_OVF_LSB + ch]) begin
        ovf_q[ch] <= 1'b0;
      end
    end

    // level mode flag follows low pin
    // edge flag held until cleared; set beats clear
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
        irq_q[ch] <= 1'b0;
      end else if (!cfg[ch].edge_sel) begin
        irq_q[ch] <= ~s2_q[ch];
      end else if (fell(s3_q[ch], s2_q[ch])) begin
        irq_q[ch] <= 1'b1;
      end else if (ack[ch] || (wr_flags && APB_I.pwdata[`TEI_FLG_IRQ_LSB + ch])) begin
        irq_q[ch] <= 1'b0;
      end
    end

    // ==========================================================
    // Channel checks
    a_edge_sets_flag: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      cfg[ch].edge_sel && fell(s3_q[ch], s2_q[ch]) |=> irq_q[ch])
      else $error("falling edge did not set flag");

    a_level_follows: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      !cfg[ch].edge_sel |=> irq_q[ch] == !$past(s2_q[ch]))
      else $error("level flag does not follow pin");

    a_edge_sticky: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      cfg[ch].edge_sel && irq_q[ch] && !ack[ch] && !wr_flags
      ##1 cfg[ch].edge_sel |-> irq_q[ch])
      else $error("edge flag dropped without clear");

    a_pin_count: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      cfg[ch].cnt_mode && run_en[ch] && fell(s3_q[ch+2], s2_q[ch+2]) && !wr_cnt[ch]
      |=> cnt_q[ch] == $past(cnt_q[ch]) + 16'h0001)
      else $error("count pin edge not counted");

    a_gate_holds: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      cfg[ch].gate && !s2_q[ch] && !wr_cnt[ch] |=> $stable(cnt_q[ch]))
      else $error("gated timer advanced");

    a_count_wraps: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      inc[ch] && !wr_cnt[ch] && cnt_q[ch] == 16'hFFFF
      |=> cnt_q[ch] == 16'h0000 && ovf_q[ch])
      else $error("count did not wrap at 16 bits");

    a_down_frozen: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      pm_q == PM_DOWN && !wr_cnt[ch] |=> $stable(cnt_q[ch]))
      else $error("timer moved in power down");

    a_edge_no_false: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      cfg[ch].edge_sel && !irq_q[ch] && !fell(s3_q[ch], s2_q[ch]) |=> !irq_q[ch])
      else $error("edge flag set without falling edge");

    a_flag_clear: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      cfg[ch].edge_sel && !fell(s3_q[ch], s2_q[ch]) &&
      (ack[ch] || (wr_flags && APB_I.pwdata[`TEI_FLG_IRQ_LSB + ch])) |=> !irq_q[ch])
      else $error("edge flag not cleared");

    a_count_load: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      wr_cnt[ch] |=> cnt_q[ch] == $past(APB_I.pwdata[15:0]))
      else $error("count load lost");

    a_timer_step: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      !cfg[ch].cnt_mode && run_en[ch] && tick && !wr_cnt[ch]
      |=> cnt_q[ch] == $past(cnt_q[ch]) + 16'h0001)
      else $error("timer missed a tick");

    // Set beats clear, so only a clear with no wrap must drop the marker
    a_wrap_clear: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
      !(inc[ch] && cnt_q[ch] == 16'hFFFF) && wr_flags && APB_I.pwdata[`TEI_FLG_OVF_LSB + ch]
      |=> !ovf_q[ch])
      else $error("wrap marker not cleared");

    c_pin_count: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
      cfg[ch].cnt_mode && inc[ch]);
    c_edge_flag: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
      cfg[ch].edge_sel && $rose(irq_q[ch]));
    c_flag_ack: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
      cfg[ch].edge_sel && ack[ch] && irq_q[ch]);
  end

  assign IRQ_REQUEST_FLAG_A_O = irq_q[0];
  assign IRQ_REQUEST_FLAG_B_O = irq_q[1];

  // ==========================================================
  // Block level checks
  a_sync_two_flop: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    $past(RESETN_I, 3) |-> s2_q == $past(pins, 2))
    else $error("pin not seen after two flops");

  a_down_wakes: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    pm_q == PM_DOWN && (irq_q[0] || irq_q[1]) |=> pm_q == PM_RUN)
    else $error("interrupt did not wake power down");

  a_down_clk_off: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    pm_q == PM_DOWN |-> CPU_HALT_O && !PERIPH_CLK_EN_O)
    else $error("power down left the peripheral clock on");

  a_idle_runs: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    pm_q == PM_IDLE |-> CPU_HALT_O && PERIPH_CLK_EN_O)
    else $error("idle stopped peripherals or ran processor");

  // Stepwise, so a legal move from idle to power down cannot trip it
  a_idle_ticks: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    pm_q == PM_IDLE |=> tick_q == ($past(tick) ? 4'h0 : $past(tick_q) + 4'h1))
    else $error("tick stopped in idle");

  a_pm_reserved: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    wr_ctrl && APB_I.pwdata[`TEI_PM_LSB +: 2] == 2'h3 && !irq_q[0] && !irq_q[1]
    |=> $stable(pm_q))
    else $error("reserved power code changed the mode");

  a_bad_addr_err: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    APB_I.psel && !APB_I.penable && !addr_ok(APB_I.paddr) ##1 APB_I.penable
    |-> APB_O.pslverr)
    else $error("unmapped access gave no error");

  a_good_addr_ok: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    APB_I.psel && !APB_I.penable && addr_ok(APB_I.paddr) ##1 APB_I.penable
    |-> !APB_O.pslverr)
    else $error("mapped access gave an error");

  c_wake_down: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    pm_q == PM_DOWN ##1 pm_q == PM_RUN);
  c_gated_run: cover property (@(posedge MCLK_I) disable iff (!RESETN_I)
    cfg[0].gate && run_en[0] && inc[0]);

endmodule

// >>> verification/tei_pin_model.sv
// Far-side model driving the interrupt and count pins
`timescale 1ns/1ps

module tei_pin_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] pulse_i,
  input  wire logic [3:0] low_i,
  output      logic [3:0] pins_o
);
  logic [1:0] cnt_q [4];

  // ==========================================================
  // Pulse shaping
  // Three low cycles; the bench spaces requests so high spans stay long
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n_i) begin
        cnt_q[i] <= 2'h0;
      end else if (cnt_q[i] != 2'h0) begin
        cnt_q[i] <= cnt_q[i] - 2'h1;
      end else if (pulse_i[i]) begin
        cnt_q[i] <= 2'h3;
      end
    end
  end

  // Port pins have pull-ups, so idle is high
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pins_o[i] = ~(low_i[i] | (cnt_q[i] != 2'h0));
    end
  end
endmodule

// >>> verification/tei_top_tb.sv
// Self-checking bench for the pin conditioning block
`timescale 1ns/1ps
`include "tei_cfg.svh"

module tei_top_tb;
  import tei_pkg::*;
  logic         mclk;
  logic         resetn;
  tei_apb_req_t req;
  tei_apb_rsp_t rsp;
  logic [3:0]   pulse;
  logic [3:0]   low;
  logic [3:0]   pins;
  logic [1:0]   ack;
  logic [1:0]   flg;
  logic         halt;
  logic         pclk_en;
  logic [31:0]  rdata;
  logic         rerr;
  int           err_total;
  int           check_count;

  tei_top i_dut (
    .MCLK_I              (mclk),
    .RESETN_I            (resetn),
    .APB_I               (req),
    .APB_O               (rsp),
    .EXT_IRQ_PIN_A_I     (pins[0]),
    .EXT_IRQ_PIN_B_I     (pins[1]),
    .COUNT_PIN_A_I       (pins[2]),
    .COUNT_PIN_B_I       (pins[3]),
    .IRQ_ACK_A_I         (ack[0]),
    .IRQ_ACK_B_I         (ack[1]),
    .IRQ_REQUEST_FLAG_A_O(flg[0]),
    .IRQ_REQUEST_FLAG_B_O(flg[1]),
    .CPU_HALT_O          (halt),
    .PERIPH_CLK_EN_O     (pclk_en)
  );

  tei_pin_model i_pins (
    .clk_i  (mclk),
    .rst_n_i(resetn),
    .pulse_i(pulse),
    .low_i  (low),
    .pins_o (pins)
  );

  always #5 mclk = ~mclk;

  // ==========================================================
  // Helpers
  task automatic end_sim();
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Request held until pready seen high at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    @(posedge mclk);
    while (rsp.pready !== 1'b1) @(posedge mclk);
    rdata = rsp.prdata;
    rerr  = rsp.pslverr;
    req <= '0;
  endtask

  task automatic pulse_pin(input int p);
    pulse[p] <= 1'b1;
    cyc(1);
    pulse[p] <= 1'b0;
    cyc(8);
  endtask

  // ==========================================================
  // Tests
  initial begin
    mclk = 1'b0; resetn = 1'b0; req = '0; pulse = 4'h0; low = 4'h0; ack = 2'h0;
    err_total = 0; check_count = 0;
    cyc(4);
    resetn <= 1'b1;
    xfer(1'b0, `TEI_OFF_TIMER_CTL, 32'h0); chk("ctl_rst", 32'h0, rdata);
    xfer(1'b0, `TEI_OFF_FLAGS, 32'h0); chk("flags_rst", 32'h0, rdata);
    chk("halt_rst", 32'h0, halt);
    chk("pclk_rst", 32'h1, pclk_en);
    xfer(1'b1, `TEI_OFF_TIMER_CTL, 32'h99);
    for (int c = 0; c < 2; c++) repeat (c + 2) pulse_pin(2 + c);
    for (int c = 0; c < 2; c++) begin
      xfer(1'b0, `TEI_OFF_COUNT_A + 4 * c, 32'h0); chk("event_count", c + 2, rdata);
    end
    // Wrap of the full 16-bit range on both counters
    for (int c = 0; c < 2; c++) begin
      xfer(1'b1, `TEI_OFF_COUNT_A + 4 * c, 32'hFFFF);
      pulse_pin(2 + c);
      xfer(1'b0, `TEI_OFF_COUNT_A + 4 * c, 32'h0); chk("count_wrap", 32'h0, rdata);
      xfer(1'b0, `TEI_OFF_FLAGS, 32'h0); chk("wrap_flag", 32'h4 << c, rdata);
      xfer(1'b1, `TEI_OFF_FLAGS, 32'h4 << c);
      xfer(1'b0, `TEI_OFF_FLAGS, 32'h0); chk("wrap_clr", 32'h0, rdata);
    end
    xfer(1'b1, `TEI_OFF_TIMER_CTL, 32'h44);
    for (int c = 0; c < 2; c++) begin
      pulse_pin(c); chk("edge_flag", 32'h1, flg[c]);
      cyc(20); chk("edge_hold", 32'h1, flg[c]);
      xfer(1'b1, `TEI_OFF_FLAGS, 32'h1 << c); cyc(1); chk("flag_w1c", 32'h0, flg[c]);
      pulse_pin(c);
      ack[c] <= 1'b1; cyc(1); ack[c] <= 1'b0; cyc(1);
      chk("flag_ack", 32'h0, flg[c]);
    end
    xfer(1'b1, `TEI_OFF_TIMER_CTL, 32'h0);
    for (int c = 0; c < 2; c++) begin
      low <= 4'h5 << c; cyc(3); chk("sync_delay", 32'h0, flg[c]);
      cyc(4); chk("level_flag", 32'h1, flg[c]);
      xfer(1'b0, `TEI_OFF_FLAGS, 32'h0); chk("pin_levels", 32'h51 << c, rdata);
      low <= 4'h0; cyc(8); chk("level_follow", 32'h0, flg[c]);
    end
    // Gate held low must stop the timer
    for (int c = 0; c < 2; c++) begin
      xfer(1'b1, `TEI_OFF_TIMER_CTL, 32'h3 << (4 * c));
      low[c] <= 1'b1;
      xfer(1'b1, `TEI_OFF_COUNT_A + 4 * c, 32'h0);
      cyc(40);
      xfer(1'b0, `TEI_OFF_COUNT_A + 4 * c, 32'h0); chk("gated", 32'h0, rdata);
      low[c] <= 1'b0; cyc(40);
      xfer(1'b0, `TEI_OFF_COUNT_A + 4 * c, 32'h0);
      chk("ungated", 32'h1, rdata inside {[2:5]});
    end
    xfer(1'b1, `TEI_OFF_COUNT_A, 32'h0);
    xfer(1'b1, `TEI_OFF_TIMER_CTL, 32'h101); cyc(1);
    chk("halt_idle", 32'h1, halt);
    chk("pclk_idle", 32'h1, pclk_en);
    cyc(36);
    xfer(1'b0, `TEI_OFF_COUNT_A, 32'h0); chk("idle_runs", 32'h1, rdata inside {[2:5]});
    low[0] <= 1'b1; cyc(8);
    chk("idle_flag", 32'h1, flg[0]);
    chk("idle_wake", 32'h0, halt);
    low[0] <= 1'b0; cyc(8);
    xfer(1'b1, `TEI_OFF_TIMER_CTL, 32'h201);
    xfer(1'b1, `TEI_OFF_COUNT_A, 32'h5);
    cyc(40);
    xfer(1'b0, `TEI_OFF_COUNT_A, 32'h0); chk("down_frozen", 32'h5, rdata);
    chk("pclk_down", 32'h0, pclk_en);
    low[1] <= 1'b1; cyc(8);
    chk("down_wake", 32'h1, pclk_en);
    low[1] <= 1'b0; cyc(8);
    // Reserved power code leaves idle alone
    xfer(1'b1, `TEI_OFF_TIMER_CTL, 32'h100);
    xfer(1'b1, `TEI_OFF_TIMER_CTL, 32'h300);
    xfer(1'b0, `TEI_OFF_TIMER_CTL, 32'h0); chk("pm_reserved", 32'h100, rdata);
    chk("halt_reserved", 32'h1, halt);
    xfer(1'b0, 12'h010, 32'h0);
    chk("unmap_rd_err", 32'h1, rerr);
    chk("unmap_rd_data", 32'h0, rdata);
    xfer(1'b1, 12'h010, 32'hFF); chk("unmap_wr_err", 32'h1, rerr);
    xfer(1'b1, `TEI_OFF_TIMER_CTL, 32'h0); chk("mapped_err", 32'h0, rerr);
    end_sim();
  end

  // Whole sequence needs well under 3000 cycles
  initial begin
    cyc(20000);
    err_total++;
    end_sim();
  end
endmodule
